// >>> rtl/branch_call_return_sequencer.sv
// Program-flow sequencer: branches, calls and returns of the core.
// Assumes one word is offered per cycle by the fetch logic and that the
// bank bit ops and interrupt entry are decoded elsewhere as pulses.
`timescale 1ns/1ns
`include "branch_call_return_cfg.svh"
module branch_call_return_sequencer
	import branch_call_return_pkg::*;
#(
	parameter int PAGE_W = 7,
	parameter int STACK_DEPTH = 8,
	parameter int DP_W = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Instruction word handshake.
	input wire logic [9:0] insnWord,
	input wire logic insnValid,
	output logic insnReady,
	// Registers feeding indirect targets.
	input wire logic [2:0] dRegister,
	input wire logic [3:0] accum,
	// Bank bit ops.
	input wire logic setBankOp,
	input wire logic clearBankOp,
	// Interrupt entry and context to save.
	input wire logic intTake,
	input wire logic [PAGE_W-1:0] intPage,
	input wire logic [6:0] intLow,
	input wire logic [DP_W-1:0] dataPtrIn,
	input wire logic carryIn,
	input wire logic skipIn,
	input wire logic nopModeIn,
	input wire logic [3:0] regBIn,
	// Program counter and stack.
	output logic [PAGE_W-1:0] programCounterPage,
	output logic [6:0] programCounterLow,
	output logic [$clog2(STACK_DEPTH)-1:0] stackPointer,
	output logic bankBit,
	output logic skipPending,
	// Context restored by interrupt return.
	output logic restoreStrobe,
	output logic [DP_W-1:0] dataPtrOut,
	output logic carryOut,
	output logic skipOut,
	output logic nopModeOut,
	output logic [3:0] accOut,
	output logic [3:0] regBOut
);
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam int RET_W = PAGE_W + 7;

	// Page from bank bit, p5 and p4..p0, cut to the variant's width.
	function automatic logic [PAGE_W-1:0] makePage(input logic bank, input logic p5,
		input logic [4:0] low5);
		logic [6:0] full;
		full = {bank, p5, low5};
		return full[PAGE_W-1:0]; // RQ12 RQ13
	endfunction

	seq_state_t state; // Sequencer phase.
	flow_kind_t pendKind; // Two-word kind awaiting second word.
	logic [4:0] firstLow; // Page bits p4..p0 of the first word.
	logic [RET_W-1:0] stackRead; // Entry at the stack pointer.
	logic [SP_W-1:0] next_stackPointer; // Stack pointer after this cycle.
	logic stackPush; // Push this cycle.
	logic stackPop; // Pop this cycle.
	logic [RET_W-1:0] pushData; // Return address to push.
	logic take; // Word accepted this cycle.
	logic execIdle; // Executable first word this cycle.
	logic execSecond; // Second word accepted this cycle.
	logic intAccept; // Interrupt entry this cycle.
	logic [6:0] seqLow; // Low part plus one.
	logic [DP_W-1:0] savedDataPtr; // Context saved at interrupt entry.
	logic savedCarry;
	logic savedSkip;
	logic savedNop;
	logic [3:0] savedAcc;
	logic [3:0] savedRegB;

	// A plain return holds the word port for its second cycle.
	assign insnReady = state != SEQ_RETURN && !(intTake && state == SEQ_IDLE); // RQ10
	assign take = insnValid && insnReady;
	assign intAccept = intTake && state == SEQ_IDLE;
	assign execIdle = take && state == SEQ_IDLE && !skipPending;
	assign execSecond = take && state == SEQ_SECOND;
	assign seqLow = programCounterLow + 7'h01;

	// Push and pop decisions and the stack pointer's next value.
	always_comb begin
		stackPush = 1'b0;
		stackPop = 1'b0;
		pushData = {programCounterPage, seqLow};
		if (intAccept) begin
			stackPush = 1'b1;
			pushData = {programCounterPage, programCounterLow};
		end else if (execIdle && insnWord[9:7] == `TOP3_CALL_PAGE_TWO) begin
			stackPush = 1'b1; // RQ4
		end else if (execSecond && (pendKind == FLOW_CALL_FAR || pendKind == FLOW_CALL_IND)) begin
			stackPush = 1'b1; // RQ5 RQ6
		end else if (execIdle && (insnWord == `WORD_RETURN_INTERRUPT
			|| insnWord == `WORD_RETURN_PLAIN || insnWord == `WORD_RETURN_SKIP)) begin
			stackPop = 1'b1; // RQ7 RQ10 RQ11
		end
		if (stackPush) begin
			next_stackPointer = stackPointer + SP_W'(1);
		end else if (stackPop) begin
			next_stackPointer = stackPointer - SP_W'(1);
		end else begin
			next_stackPointer = stackPointer;
		end
	end

	// Return stack storage; read data always mirror the current top.
	return_stack_mem #(.WIDTH(RET_W), .DEPTH(STACK_DEPTH), .AW(SP_W)) stackMem (
		.ref_clk(ref_clk),
		.wrEn(stackPush),
		.wrAddr(next_stackPointer),
		.wrData(pushData),
		.rdAddr(next_stackPointer),
		.rdData(stackRead)
	);

	// Stack pointer; starts at all ones so the first push lands in entry zero.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stackPointer <= '1;
		end else begin
			stackPointer <= next_stackPointer;
		end
	end

	// Bank bit supplying the top page bit of far forms.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bankBit <= 1'b0;
		end else if (setBankOp) begin
			bankBit <= 1'b1; // RQ13
		end else if (clearBankOp) begin
			bankBit <= 1'b0; // RQ13
		end
	end

	// Sequencer phase and the captured first word.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= SEQ_IDLE;
			pendKind <= FLOW_BRANCH_FAR;
			firstLow <= 5'h00;
		end else begin
			case (state)
				SEQ_IDLE: begin
					if (execIdle) begin
						firstLow <= insnWord[4:0];
						if (insnWord[9:5] == `TOP5_BRANCH_FAR) begin
							state <= SEQ_SECOND; // RQ14
							pendKind <= FLOW_BRANCH_FAR;
						end else if (insnWord[9:5] == `TOP5_CALL_FAR) begin
							state <= SEQ_SECOND; // RQ14
							pendKind <= FLOW_CALL_FAR;
						end else if (insnWord == `WORD_BRANCH_FAR_INDIRECT) begin
							state <= SEQ_SECOND; // RQ14
							pendKind <= FLOW_BRANCH_IND;
						end else if (insnWord == `WORD_CALL_FAR_INDIRECT) begin
							state <= SEQ_SECOND; // RQ14
							pendKind <= FLOW_CALL_IND;
						end else if (insnWord == `WORD_RETURN_PLAIN
							|| insnWord == `WORD_RETURN_SKIP) begin
							state <= SEQ_RETURN; // RQ10 RQ11
						end
					end
				end
				SEQ_SECOND: begin
					if (execSecond) begin
						state <= SEQ_IDLE;
					end
				end
				SEQ_RETURN: begin
					state <= SEQ_IDLE;
				end
				default: begin
					state <= SEQ_IDLE;
				end
			endcase
		end
	end

	// Program counter: sequential advance or a flow change.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			programCounterPage <= PAGE_W'(`PC_PAGE_RESET);
			programCounterLow <= `PC_LOW_RESET;
		end else if (intAccept) begin
			programCounterPage <= intPage;
			programCounterLow <= intLow;
		end else if (take && state == SEQ_IDLE && skipPending) begin
			programCounterLow <= seqLow;
		end else if (execIdle) begin
			if (insnWord[9:7] == `TOP3_BRANCH_IN_PAGE) begin
				programCounterLow <= insnWord[6:0]; // RQ1
			end else if (insnWord[9:7] == `TOP3_CALL_PAGE_TWO) begin
				programCounterPage <= PAGE_W'(`CALL_PAGE_TWO_PAGE); // RQ4
				programCounterLow <= insnWord[6:0]; // RQ4
			end else if (insnWord == `WORD_RETURN_INTERRUPT) begin
				{programCounterPage, programCounterLow} <= stackRead; // RQ7
			end else if (insnWord == `WORD_RETURN_PLAIN || insnWord == `WORD_RETURN_SKIP) begin
				{programCounterPage, programCounterLow} <= stackRead; // RQ10 RQ11
			end else begin
				programCounterLow <= seqLow; // RQ14
			end
		end else if (execSecond) begin
			case (pendKind)
				FLOW_BRANCH_FAR, FLOW_CALL_FAR: begin
					programCounterPage <= makePage(bankBit, insnWord[7], firstLow); // RQ2 RQ5
					programCounterLow <= insnWord[6:0]; // RQ2 RQ5
				end
				FLOW_BRANCH_IND, FLOW_CALL_IND: begin
					programCounterPage <= makePage(bankBit, insnWord[7],
						{insnWord[6], insnWord[3:0]}); // RQ3 RQ6
					programCounterLow <= {dRegister, accum}; // RQ3 RQ6
				end
				default: begin
					programCounterLow <= seqLow;
				end
			endcase
		end
	end

	// Skip flag raised by return-and-skip, consumed by the next word.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			skipPending <= 1'b0;
		end else if (state == SEQ_RETURN && firstLow == 5'(`WORD_RETURN_SKIP)) begin
			// The low five bits of the captured return word tell skip from plain return.
			skipPending <= 1'b1; // RQ11
		end else if (take && state == SEQ_IDLE) begin
			skipPending <= 1'b0;
		end
	end

	// Context saved at interrupt entry.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			savedDataPtr <= '0;
			savedCarry <= 1'b0;
			savedSkip <= 1'b0;
			savedNop <= 1'b0;
			savedAcc <= 4'h0;
			savedRegB <= 4'h0;
		end else if (intAccept) begin
			savedDataPtr <= dataPtrIn;
			savedCarry <= carryIn;
			savedSkip <= skipIn;
			savedNop <= nopModeIn;
			savedAcc <= accum;
			savedRegB <= regBIn;
		end
	end

	// Context restore presented with a one-cycle strobe after interrupt return.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			restoreStrobe <= 1'b0;
			dataPtrOut <= '0;
			carryOut <= 1'b0;
			skipOut <= 1'b0;
			nopModeOut <= 1'b0;
			accOut <= 4'h0;
			regBOut <= 4'h0;
		end else begin
			restoreStrobe <= execIdle && insnWord == `WORD_RETURN_INTERRUPT; // RQ8 RQ9
			if (execIdle && insnWord == `WORD_RETURN_INTERRUPT) begin
				dataPtrOut <= savedDataPtr; // RQ8
				carryOut <= savedCarry; // RQ9
				skipOut <= savedSkip; // RQ9
				nopModeOut <= savedNop; // RQ9
				accOut <= savedAcc; // RQ9
				regBOut <= savedRegB; // RQ9
			end
		end
	end

	// In-page branch keeps the page and loads the immediate.
	property p_in_page;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && insnWord[9:7] == `TOP3_BRANCH_IN_PAGE) |=>
			programCounterLow == $past(insnWord[6:0]) && $stable(programCounterPage);
	endproperty
	a_in_page: assert property (p_in_page) else $error("in-page branch target wrong"); // RQ1

	// Far branch loads page and low only after its second word.
	property p_far_branch;
		@(posedge ref_clk) disable iff (reset)
		(execSecond && pendKind == FLOW_BRANCH_FAR) |=>
			programCounterLow == $past(insnWord[6:0])
			&& programCounterPage[4:0] == $past(firstLow) && $stable(stackPointer);
	endproperty
	a_far_branch: assert property (p_far_branch) else $error("far branch target wrong"); // RQ2

	// Indirect branch takes the low part from D and accumulator.
	property p_ind_branch;
		@(posedge ref_clk) disable iff (reset)
		(execSecond && pendKind == FLOW_BRANCH_IND) |=>
			programCounterLow == $past({dRegister, accum}) && $stable(stackPointer);
	endproperty
	a_ind_branch: assert property (p_ind_branch) else $error("indirect branch wrong"); // RQ3

	// Page-two call moves to page two and bumps the stack pointer.
	property p_call_two;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && insnWord[9:7] == `TOP3_CALL_PAGE_TWO) |=>
			programCounterPage == PAGE_W'(`CALL_PAGE_TWO_PAGE)
			&& stackPointer == $past(stackPointer) + SP_W'(1);
	endproperty
	a_call_two: assert property (p_call_two) else $error("page-two call wrong"); // RQ4

	// Far calls push on the second word only.
	property p_call_far;
		@(posedge ref_clk) disable iff (reset)
		(execSecond && (pendKind == FLOW_CALL_FAR || pendKind == FLOW_CALL_IND)) |=>
			stackPointer == $past(stackPointer) + SP_W'(1);
	endproperty
	a_call_far: assert property (p_call_far) else $error("far call did not push"); // RQ5

	// A far call first word, direct or indirect, leaves the counter page alone and waits.
	property p_second_wait;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && (insnWord[9:5] == `TOP5_CALL_FAR || insnWord == `WORD_CALL_FAR_INDIRECT))
			|=> state == SEQ_SECOND && $stable(programCounterPage) && $stable(stackPointer);
	endproperty
	a_second_wait: assert property (p_second_wait) else $error("early far update"); // RQ14

	// Interrupt return pops and strobes the restored context in one cycle.
	property p_rti;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && insnWord == `WORD_RETURN_INTERRUPT) |=>
			restoreStrobe && dataPtrOut == savedDataPtr
			&& stackPointer == $past(stackPointer) - SP_W'(1) && state == SEQ_IDLE;
	endproperty
	a_rti: assert property (p_rti) else $error("interrupt return wrong"); // RQ7

	// Plain return blocks the word port for its second cycle.
	property p_rt;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && insnWord == `WORD_RETURN_PLAIN) |=> !insnReady ##1 insnReady || intTake;
	endproperty
	a_rt: assert property (p_rt) else $error("plain return not two cycles"); // RQ10

	// Return-and-skip arms the skip two cycles later.
	property p_rts;
		@(posedge ref_clk) disable iff (reset)
		(execIdle && insnWord == `WORD_RETURN_SKIP) |-> ##2 skipPending;
	endproperty
	a_rts: assert property (p_rts) else $error("return-and-skip did not skip"); // RQ11

	// A set bank op raises the bank bit.
	property p_bank;
		@(posedge ref_clk) disable iff (reset)
		setBankOp |=> bankBit;
	endproperty
	a_bank: assert property (p_bank) else $error("bank bit not set"); // RQ13
endmodule // branch_call_return_sequencer

// >>> rtl/branch_call_return_cfg.svh
// Constants of the program-flow sequencer: opcodes, field positions, reset values.
// Assumes it is included by bare name from the sequencer file.
//
// What this block does
// RQ1 - In-page branch loads low part, keeps page.
// RQ2 - Far branch: two words, loads page and low.
// RQ3 - Indirect far branch: low from D and accumulator.
// RQ4 - Page-two call pushes PC, page becomes two.
// RQ5 - Far call pushes PC, loads page and low.
// RQ6 - Indirect far call pushes PC, low from registers.
// RQ7 - Interrupt return pops PC in one cycle.
// RQ8 - Interrupt return restores the data pointer.
// RQ9 - Interrupt return restores carry, skip, mode, A, B.
// RQ10 - Plain return pops PC over two cycles.
// RQ11 - Return-and-skip pops, then skips next instruction.
// RQ12 - Page width is five, six or seven bits.
// RQ13 - Top page bit comes from the bank bit.
// RQ14 - Second word fetched next; update after both captured.
`ifndef BRANCH_CALL_RETURN_CFG_SVH
`define BRANCH_CALL_RETURN_CFG_SVH

// Upper three bits of one-word branch and call forms.
`define TOP3_BRANCH_IN_PAGE 3'h3
`define TOP3_CALL_PAGE_TWO 3'h2
// Upper five bits of the first word of far forms.
`define TOP5_BRANCH_FAR 5'h07
`define TOP5_CALL_FAR 5'h06
// Whole-word encodings.
`define WORD_BRANCH_FAR_INDIRECT 10'h010
`define WORD_CALL_FAR_INDIRECT 10'h030
`define WORD_RETURN_PLAIN 10'h044
`define WORD_RETURN_SKIP 10'h045
`define WORD_RETURN_INTERRUPT 10'h046
// Upper two bits of every second word.
`define SECOND_WORD_TAG 2'h2
// Page loaded by the page-two call.
`define CALL_PAGE_TWO_PAGE 7'h02
// Reset values.
`define PC_PAGE_RESET 7'h00
`define PC_LOW_RESET 7'h00

`endif

// >>> rtl/branch_call_return_pkg.sv
// Types shared by the program-flow sequencer.
// Assumes the constants header sits beside it.
package branch_call_return_pkg;
	// Sequencer phase.
	typedef enum {SEQ_IDLE, SEQ_SECOND, SEQ_RETURN} seq_state_t;
	// Kind of two-word instruction waiting for its second word.
	typedef enum {FLOW_BRANCH_FAR, FLOW_BRANCH_IND, FLOW_CALL_FAR, FLOW_CALL_IND} flow_kind_t;
endpackage

// >>> rtl/return_stack_mem.sv
// Return stack storage with a registered read port.
// Assumes one clock; the read address is the stack pointer's next value.
`timescale 1ns/1ns
module return_stack_mem #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock.
	input wire logic ref_clk,
	// Write port.
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// Read port.
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	// Storage array, no reset needed.
	logic [WIDTH-1:0] mem [DEPTH];

	// Write, and read with write-through so a fresh push is seen at once.
	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (wrEn && wrAddr == rdAddr) begin
			rdData <= wrData;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule // return_stack_mem

// >>> testbench/prog_mem_model.sv
// Program memory model that offers queued instruction words, one per cycle.
// Assumes the sequencer takes a word at a rising edge with valid and ready high.
`timescale 1ns/1ns
module prog_mem_model (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset,
	// Instruction word handshake.
	input wire logic insnReady,
	output logic [9:0] insnWord,
	output logic insnValid
);
	// Queued words.
	logic [9:0] mem [0:63];
	// Read and write positions in the queue.
	int rd = 0;
	int wr = 0;

	// Appends one word to the queue.
	task automatic put(input logic [9:0] w);
		mem[wr] = w;
		wr = wr + 1;
	endtask

	// A word stands until taken; with nothing queued the bus shows a changing pattern.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			insnValid <= 1'b0;
			insnWord <= 10'h000;
		end else begin
			// A taken word moves the read position on.
			if (insnValid && insnReady) begin
				rd = rd + 1;
			end
			if (rd < wr) begin
				insnValid <= 1'b1;
				insnWord <= mem[rd];
			end else begin
				insnValid <= 1'b0;
				insnWord <= ~insnWord;
			end
		end
	end
endmodule // prog_mem_model

// >>> testbench/test_branch_call_return_sequencer.sv
// Self-checking bench of the program-flow sequencer with a program memory model.
// Assumes default parameters: seven page bits, eight stack entries.
`timescale 1ns/1ns
module test_branch_call_return_sequencer;
	import branch_call_return_pkg::*;
	// Clock, reset and design signals.
	logic ref_clk, reset, insnReady, insnValid, setBankOp, clearBankOp, intTake;
	logic carryIn, skipIn, nopModeIn, bankBit, skipPending, restoreStrobe;
	logic carryOut, skipOut, nopModeOut;
	logic [9:0] insnWord;
	logic [2:0] dRegister, stackPointer;
	logic [3:0] accum, regBIn, accOut, regBOut;
	logic [6:0] intPage, intLow, programCounterPage, programCounterLow;
	logic [7:0] dataPtrIn, dataPtrOut;
	// Expected program counter, stack pointer and stack contents.
	logic [6:0] ePage, eLow;
	logic [2:0] eSp;
	logic [13:0] stk [0:7];
	// Counters of mismatches and comparisons.
	int fails = 0;
	int nTests = 0;

	// Device under test.
	branch_call_return_sequencer uut (.ref_clk(ref_clk), .reset(reset), .insnWord(insnWord),
		.insnValid(insnValid), .insnReady(insnReady), .dRegister(dRegister), .accum(accum),
		.setBankOp(setBankOp), .clearBankOp(clearBankOp), .intTake(intTake),
		.intPage(intPage), .intLow(intLow), .dataPtrIn(dataPtrIn), .carryIn(carryIn),
		.skipIn(skipIn), .nopModeIn(nopModeIn), .regBIn(regBIn),
		.programCounterPage(programCounterPage), .programCounterLow(programCounterLow),
		.stackPointer(stackPointer), .bankBit(bankBit), .skipPending(skipPending),
		.restoreStrobe(restoreStrobe), .dataPtrOut(dataPtrOut), .carryOut(carryOut),
		.skipOut(skipOut), .nopModeOut(nopModeOut), .accOut(accOut), .regBOut(regBOut));
	// Program memory on the far side.
	prog_mem_model pm (.ref_clk(ref_clk), .reset(reset), .insnReady(insnReady),
		.insnWord(insnWord), .insnValid(insnValid));

	// Clock of 20 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("comparisons %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Waits, bounded, until the model has handed over every queued word.
	task automatic drain();
		for (int i = 0; i <= 20; i++) begin
			@(posedge ref_clk);
			#1;
			if (pm.rd == pm.wr) begin
				return;
			end
		end
		fails++;
		$display("mismatch drain expected empty seen busy");
		results();
	endtask

	// Compares program counter and stack pointer with the expected ones.
	task automatic checkPc();
		check("page", 16'(programCounterPage), 16'(ePage));
		check("low", 16'(programCounterLow), 16'(eLow));
		check("sp", 16'(stackPointer), 16'(eSp));
	endtask

	// Pushes an address on the expected stack.
	task automatic push(input logic [6:0] p, input logic [6:0] l);
		eSp = eSp + 3'h1;
		stk[eSp] = {p, l};
	endtask

	// Pops the expected stack into the expected program counter.
	task automatic pop();
		{ePage, eLow} = stk[eSp];
		eSp = eSp - 3'h1;
	endtask

	// Main sequence.
	initial begin
		reset <= 1'b1;
		{setBankOp, clearBankOp, intTake, carryIn, skipIn, nopModeIn} <= 6'h00;
		dRegister <= 3'h5;
		accum <= 4'hC;
		regBIn <= 4'h9;
		intPage <= 7'h11;
		intLow <= 7'h22;
		dataPtrIn <= 8'hA5;
		{ePage, eLow, eSp} = {7'h00, 7'h00, 3'h7};
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
		checkPc();
		check("bank", 16'(bankBit), 16'h0000);
		// In-page branch keeps the page.
		pm.put(10'h1A5);
		drain();
		eLow = 7'h25;
		checkPc();
		// Bank bit supplies page bit six of the far branch.
		@(posedge ref_clk);
		setBankOp <= 1'b1;
		@(posedge ref_clk);
		setBankOp <= 1'b0;
		#1;
		check("bank", 16'(bankBit), 16'h0001);
		pm.put(10'h0E3);
		drain();
		eLow = 7'h26;
		checkPc();
		pm.put(10'h245);
		drain();
		{ePage, eLow} = {7'h43, 7'h45};
		checkPc();
		@(posedge ref_clk);
		clearBankOp <= 1'b1;
		@(posedge ref_clk);
		clearBankOp <= 1'b0;
		#1;
		check("bank", 16'(bankBit), 16'h0000);
		// Page-two call, far call and indirect far call, back to back.
		pm.put(10'h155);
		drain();
		push(7'h43, 7'h46);
		{ePage, eLow} = {7'h02, 7'h55};
		checkPc();
		pm.put(10'h0C5);
		pm.put(10'h212);
		drain();
		push(7'h02, 7'h57);
		{ePage, eLow} = {7'h05, 7'h12};
		checkPc();
		pm.put(10'h030);
		pm.put(10'h24A);
		drain();
		push(7'h05, 7'h14);
		{ePage, eLow} = {7'h1A, 7'h5C};
		checkPc();
		// Plain return refuses a word in its second cycle.
		pm.put(10'h044);
		drain();
		pop();
		checkPc();
		check("ready", 16'(insnReady), 16'h0000);
		// Return-and-skip pops, arms the skip, then drops the following in-page branch.
		pm.put(10'h045);
		drain();
		pop();
		checkPc();
		@(posedge ref_clk);
		#1;
		check("skip", 16'(skipPending), 16'h0001);
		pm.put(10'h1A0);
		drain();
		eLow = eLow + 7'h01;
		checkPc();
		check("skip", 16'(skipPending), 16'h0000);
		// Indirect far branch takes its low part from D and the accumulator.
		dRegister <= 3'h2;
		accum <= 4'h7;
		pm.put(10'h010);
		pm.put(10'h24A);
		drain();
		{ePage, eLow} = {7'h1A, 7'h27};
		checkPc();
		// Interrupt entry saves context; its return restores it.
		@(posedge ref_clk);
		{intTake, carryIn, nopModeIn} <= 3'h7;
		{intPage, intLow} <= {7'h6B, 7'h3E};
		@(posedge ref_clk);
		intTake <= 1'b0;
		#1;
		push(ePage, eLow);
		{ePage, eLow} = {7'h6B, 7'h3E};
		checkPc();
		@(posedge ref_clk);
		{carryIn, nopModeIn, skipIn} <= 3'h1;
		{accum, regBIn, dataPtrIn} <= 16'h3000;
		dRegister <= 3'h0;
		#1;
		pm.put(10'h046);
		drain();
		pop();
		checkPc();
		check("strobe", 16'(restoreStrobe), 16'h0001);
		check("dp", 16'(dataPtrOut), 16'h00A5);
		check("ctx", 16'({carryOut, skipOut, nopModeOut, accOut, regBOut}), 16'h0579);
		@(posedge ref_clk);
		#1;
		check("strobe", 16'(restoreStrobe), 16'h0000);
		results();
	end
endmodule // test_branch_call_return_sequencer
